//--- design/ifs_core.sv
// instruction fetch sequencer: clock phases, pipeline, counter, rom address
// How it works
// - the processor clock is the oscillator divided by two.
// - the processor clock makes four one-hot phases, four per instruction cycle.
// - the next word is fetched while the previous one executes, one per cycle.
// - a counter-changing instruction costs a second, dummy cycle.
// - the instruction pointer is thirteen bits, 8192 words per bank.
// - each fetch advances the instruction pointer by one.
// - jumps, low-byte writes, calls, reset, interrupts and returns load it.
// - a taken skip drops the fetched word and runs a dummy cycle instead.
// - the low byte is readable and writable at register address 06H.
// - writing the low byte is a short jump inside the current 256-word page.
// - one 16-bit rom address bus serves fetches and wavetable reads.
// - fetch addresses combine the two bank bits and the thirteen pointer bits.
// - the fetch address is bank times 8192 plus the pointer.
// - after reset fetching starts at 000H of bank zero.
// - a bank change takes effect at the end of the next instruction cycle, dummy or not.
// - an acknowledged first-timer interrupt goes to 008H of the current bank.
module ifs_core (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic [ifs_pkg::DATA_W-1:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [ifs_pkg::DATA_W-1:0] regRdata,
	// execution control from decoder, stack and interrupt logic
	input wire ifs_pkg::ifs_ctl_s ctlReq,
	input wire ifs_pkg::ifs_bank_s bankReq,
	// wavetable request
	input wire logic waveReq,
	input wire logic [ifs_pkg::WAVE_W-1:0] waveStart,
	output logic [ifs_pkg::WORD_W-1:0] waveData,
	output logic waveDone,
	// shared rom
	output logic [ifs_pkg::ROM_AW-1:0] romAddr,
	input wire logic [ifs_pkg::WORD_W-1:0] romData,
	// timing and pipeline outputs
	output logic procClk,
	output logic [ifs_pkg::PHASES-1:0] phaseClk,
	output logic cycleEnd,
	output logic [ifs_pkg::WORD_W-1:0] execWord,
	output logic execValid,
	output logic [ifs_pkg::PC_W-1:0] instrPointer,
	output logic [ifs_pkg::BANK_W-1:0] romBankSelect
);

	// true for every control kind except none, skip included
	function automatic logic isTransfer(input ifs_pkg::ifs_ctl_e kind);
		isTransfer = (kind != ifs_pkg::CTL_NONE);
	endfunction

	// true when a register address hits the low-byte register
	function automatic logic hitLow(input logic [7:0] addr);
		hitLow = (addr == ifs_pkg::COUNTER_LOW_BYTE_OFS);
	endfunction

	// clock divider and phase state
	logic divHalf;
	logic next_divHalf;
	logic next_procClk;
	ifs_pkg::ifs_phase_e phase;
	ifs_pkg::ifs_phase_e next_phase;
	logic [ifs_pkg::PHASES-1:0] next_phaseClk;
	logic procEdge;

	// pipeline and counter state
	logic [ifs_pkg::PC_W-1:0] next_instrPointer;
	logic [ifs_pkg::BANK_W-1:0] next_romBankSelect;
	logic [ifs_pkg::BANK_W-1:0] bankPend;
	logic [ifs_pkg::BANK_W-1:0] next_bankPend;
	logic bankArmed;
	logic next_bankArmed;
	logic bankWait;
	logic next_bankWait;
	logic [ifs_pkg::WORD_W-1:0] next_execWord;
	logic next_execValid;
	logic lowPend;
	logic next_lowPend;
	logic [ifs_pkg::DATA_W-1:0] lowData;
	logic [ifs_pkg::DATA_W-1:0] next_lowData;

	// register port and wavetable state
	logic [ifs_pkg::DATA_W-1:0] next_regRdata;
	logic [ifs_pkg::WORD_W-1:0] next_waveData;
	logic next_waveDone;
	logic waveSlot;

	// divide oscillator by two, step phase on each processor clock fall
	always_comb begin
		next_divHalf = ~divHalf;
		next_procClk = next_divHalf;
		procEdge = divHalf;
		next_phase = phase;
		if (procEdge) begin
			case (phase)
				ifs_pkg::PH_T1: next_phase = ifs_pkg::PH_T2;
				ifs_pkg::PH_T2: next_phase = ifs_pkg::PH_T3;
				ifs_pkg::PH_T3: next_phase = ifs_pkg::PH_T4;
				ifs_pkg::PH_T4: next_phase = ifs_pkg::PH_T1;
				default: next_phase = ifs_pkg::PH_T1;
			endcase
		end
		next_phaseClk = '0;
		for (int i = 0; i < ifs_pkg::PHASES; i++) begin
			next_phaseClk[i] = (next_phase == ifs_pkg::ifs_phase_e'(i));
		end
	end

	// cycle boundary: last oscillator edge of phase four
	assign cycleEnd = procEdge && (phase == ifs_pkg::PH_T4);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			divHalf <= 1'b0;
			procClk <= 1'b0;
			phase <= ifs_pkg::PH_T1;
			phaseClk <= 4'h1;
		end else begin
			divHalf <= next_divHalf;
			procClk <= next_procClk;
			phase <= next_phase;
			phaseClk <= next_phaseClk;
		end
	end

	// wavetable owns the rom bus during phase two when asked
	assign waveSlot = waveReq && (phase == ifs_pkg::WAVE_PHASE);

	// shared rom address: wavetable start padded, or bank above pointer
	always_comb begin
		if (waveSlot) begin
			romAddr = {waveStart, {ifs_pkg::WAVE_PAD{1'b0}}};
		end else begin
			romAddr = {1'b0, romBankSelect, instrPointer};
		end
	end

	// wavetable data latched at end of its phase
	always_comb begin
		next_waveData = waveData;
		next_waveDone = 1'b0;
		if (waveSlot && procEdge) begin
			next_waveData = romData;
			next_waveDone = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			waveData <= ifs_pkg::WORD_RESET;
			waveDone <= 1'b0;
		end else begin
			waveData <= next_waveData;
			waveDone <= next_waveDone;
		end
	end

	// low-byte write is held until the cycle boundary, read returns the pointer low byte one clock later
	always_comb begin
		next_lowPend = lowPend;
		next_lowData = lowData;
		next_regRdata = ifs_pkg::BYTE_ZERO;
		if (regWr && hitLow(regAddr)) begin
			next_lowPend = 1'b1;
			next_lowData = regWdata;
		end else if (cycleEnd) begin
			next_lowPend = 1'b0;
		end
		if (regRd && hitLow(regAddr)) begin
			next_regRdata = instrPointer[ifs_pkg::DATA_W-1:0];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lowPend <= 1'b0;
			lowData <= ifs_pkg::BYTE_ZERO;
			regRdata <= ifs_pkg::BYTE_ZERO;
		end else begin
			lowPend <= next_lowPend;
			lowData <= next_lowData;
			regRdata <= next_regRdata;
		end
	end

	// pointer, pipeline and bank update at each instruction-cycle boundary
	always_comb begin
		next_instrPointer = instrPointer;
		next_execWord = execWord;
		next_execValid = execValid;
		next_romBankSelect = romBankSelect;
		next_bankPend = bankPend;
		next_bankArmed = bankArmed;
		next_bankWait = bankWait;
		if (cycleEnd) begin
			// fetched word moves to execute, pointer steps on
			next_execWord = romData;
			next_execValid = 1'b1;
			next_instrPointer = instrPointer + 13'h0001;
			if (lowPend) begin
				// short jump within the current page
				next_instrPointer = {instrPointer[ifs_pkg::PC_W-1:ifs_pkg::DATA_W],
					lowData};
				next_execValid = 1'b0;
			end else if (execValid && isTransfer(ctlReq.kind)) begin
				case (ctlReq.kind)
					ifs_pkg::CTL_JUMP,
					ifs_pkg::CTL_CALL,
					ifs_pkg::CTL_RET: next_instrPointer = ctlReq.target;
					ifs_pkg::CTL_SKIP: next_instrPointer = instrPointer + 13'h0001;
					ifs_pkg::CTL_TMR0: next_instrPointer = ifs_pkg::VEC_TMR0;
					ifs_pkg::CTL_TMR1: next_instrPointer = ifs_pkg::VEC_TMR1;
					default: next_instrPointer = instrPointer + 13'h0001;
				endcase
				// fetched word is discarded, dummy cycle follows
				next_execValid = 1'b0;
			end
			// bank write: armed now, applied at the end of the next instruction cycle
			if (bankArmed && !bankWait) begin
				next_romBankSelect = bankPend;
				next_bankArmed = 1'b0;
			end else if (bankWait) begin
				next_bankWait = 1'b0;
			end
			if (execValid && bankReq.write) begin
				next_bankPend = bankReq.bank;
				next_bankArmed = 1'b1;
				next_bankWait = 1'b0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			instrPointer <= ifs_pkg::PC_RESET;
			romBankSelect <= ifs_pkg::BANK_RESET;
			execWord <= ifs_pkg::WORD_RESET;
			execValid <= 1'b0;
			bankPend <= ifs_pkg::BANK_RESET;
			bankArmed <= 1'b0;
			bankWait <= 1'b0;
		end else begin
			instrPointer <= next_instrPointer;
			romBankSelect <= next_romBankSelect;
			execWord <= next_execWord;
			execValid <= next_execValid;
			bankPend <= next_bankPend;
			bankArmed <= next_bankArmed;
			bankWait <= next_bankWait;
		end
	end

endmodule

//--- design/ifs_pkg.sv
// package: constants and types for the instruction fetch sequencer
package ifs_pkg;

	// widths of counter, bank, rom bus, data byte and instruction word
	localparam int PC_W = 13;
	localparam int BANK_W = 2;
	localparam int ROM_AW = 16;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int WAVE_W = 11;
	localparam int WAVE_PAD = 5;

	// oscillator divide and phase count per instruction cycle
	localparam int OSC_DIV = 2;
	localparam int PHASES = 4;

	// register map (byte offsets on the register port)
	localparam logic [7:0] COUNTER_LOW_BYTE_OFS = 8'h06;

	// reset values and fixed vectors
	localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
	localparam logic [BANK_W-1:0] BANK_RESET = 2'h0;
	localparam logic [PC_W-1:0] VEC_TMR0 = 13'h0008;
	localparam logic [PC_W-1:0] VEC_TMR1 = 13'h000C;
	localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;

	// phase in which the wavetable owns the rom bus
	localparam logic [1:0] WAVE_PHASE = 2'h1;

	// instruction-cycle phase states
	typedef enum logic [1:0] {
		PH_T1 = 2'b00,
		PH_T2 = 2'b01,
		PH_T3 = 2'b10,
		PH_T4 = 2'b11
	} ifs_phase_e;

	// kind of counter change requested by the executing instruction
	typedef enum logic [2:0] {
		CTL_NONE = 3'b000,
		CTL_JUMP = 3'b001,
		CTL_CALL = 3'b010,
		CTL_RET = 3'b011,
		CTL_SKIP = 3'b100,
		CTL_TMR0 = 3'b101,
		CTL_TMR1 = 3'b110
	} ifs_ctl_e;

	// control request from decoder/stack/interrupt logic
	typedef struct packed {
		ifs_ctl_e kind;
		logic [PC_W-1:0] target;
	} ifs_ctl_s;

	// bank write request from an executing instruction
	typedef struct packed {
		logic write;
		logic [BANK_W-1:0] bank;
	} ifs_bank_s;

endpackage

//--- sim/ifs_rom_model.sv
// behavioural shared rom for fetch and wavetable reads
module ifs_rom_model (
	// address from the sequencer
	input wire logic [15:0] romAddr,
	// word back in the same cycle
	output logic [15:0] romData
);
	timeunit 1ns;
	timeprecision 1ns;
	// pattern gives every address its own word
	assign romData = romAddr ^ 16'hA5A5;
endmodule

//--- sim/ifs_core_properties.sv
// checker: timing and addressing relations of the fetch sequencer
module ifs_core_properties (
	// clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// register port
	input wire logic [7:0] regAddr,
	input wire logic regRd,
	input wire logic [ifs_pkg::DATA_W-1:0] regRdata,
	// requests
	input wire ifs_pkg::ifs_ctl_s ctlReq,
	input wire ifs_pkg::ifs_bank_s bankReq,
	input wire logic waveReq,
	input wire logic [ifs_pkg::WAVE_W-1:0] waveStart,
	// watched outputs
	input wire logic [ifs_pkg::ROM_AW-1:0] romAddr,
	input wire logic procClk,
	input wire logic [ifs_pkg::PHASES-1:0] phaseClk,
	input wire logic cycleEnd,
	input wire logic execValid,
	input wire logic [ifs_pkg::PC_W-1:0] instrPointer,
	input wire logic [ifs_pkg::BANK_W-1:0] romBankSelect
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// boundary of an executing instruction
	logic taken;
	assign taken = cycleEnd && execValid;
	// dummy slot after a transfer
	sequence sDummy;
		##1 !execValid;
	endsequence
	// bank held over the following instruction
	sequence sHold;
		$stable(romBankSelect)[*8];
	endsequence
	chk_clk_half: assert property (1 |=> procClk != $past(procClk))
		else $error("processor clock not halved");
	chk_phase_wrap: assert property (cycleEnd |-> phaseClk[3] ##1 phaseClk == 4'h1)
		else $error("phase wrap wrong");
	chk_cycle_len: assert property (cycleEnd |=> !cycleEnd[*7] ##1 cycleEnd)
		else $error("instruction cycle length wrong");
	chk_ptr_hold: assert property (!cycleEnd |=> $stable(instrPointer))
		else $error("pointer moved mid cycle");
	chk_jump_load: assert property (taken && ctlReq.kind inside {ifs_pkg::CTL_JUMP,
		ifs_pkg::CTL_CALL, ifs_pkg::CTL_RET} |-> sDummy ##0 instrPointer == $past(ctlReq.target))
		else $error("transfer target not loaded");
	chk_tmr0_vec: assert property (taken && ctlReq.kind == ifs_pkg::CTL_TMR0 |=>
		instrPointer == 13'h0008 && $stable(romBankSelect))
		else $error("timer vector wrong");
	chk_skip_drop: assert property (taken && ctlReq.kind == ifs_pkg::CTL_SKIP |->
		sDummy ##0 instrPointer == $past(instrPointer) + 13'h0001)
		else $error("skip wrong");
	chk_bank_late: assert property (taken && bankReq.write |=>
		sHold ##1 romBankSelect == $past(bankReq.bank, 9))
		else $error("bank switch timing wrong");
	chk_fetch_addr: assert property (!(waveReq && phaseClk[1]) |->
		romAddr == {1'b0, romBankSelect, instrPointer})
		else $error("fetch address wrong");
	chk_wave_addr: assert property (waveReq && phaseClk[1] |-> romAddr == {waveStart, 5'h00})
		else $error("wave address wrong");
	chk_read_back: assert property (regRd && regAddr == 8'h06 |=>
		regRdata == 8'($past(instrPointer)))
		else $error("low byte read wrong");
endmodule
bind ifs_core ifs_core_properties i_chk (.*);

//--- sim/ifs_core_tb.sv
// testbench: fetch sequencer through register and control ports
module ifs_core_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 1'b0, arst_n = 1'b0, regWr = 1'b0, regRd = 1'b0, waveReq = 1'b0;
	logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
	ifs_pkg::ifs_ctl_s ctlReq = '0;
	ifs_pkg::ifs_bank_s bankReq = '0;
	logic [10:0] waveStart = 11'h000;
	logic [15:0] waveData, romAddr, romData, execWord;
	logic waveDone, procClk, cycleEnd, execValid;
	logic [3:0] phaseClk;
	logic [12:0] instrPointer;
	logic [1:0] romBankSelect;
	int fails = 0, n_tests = 0;
	ifs_core i_dut (.*);
	ifs_rom_model i_rom (.*);
	// oscillator
	always #2 ref_clk = ~ref_clk;
	// verdict and end of run
	task automatic results;
		if (fails == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// compare and report
	task automatic ck(input string n, input logic [15:0] e, s);
		n_tests++;
		if (s !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	// wait past the next instruction boundary
	task automatic nxt;
		do
			@(negedge ref_clk);
		while (!cycleEnd);
		@(negedge ref_clk);
	endtask
	// register write and read cycles
	task automatic wr(input logic [7:0] a, d);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge ref_clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge ref_clk);
		regRd <= 1'b0;
		@(negedge ref_clk);
		ck("regRdata", {8'h00, e}, {8'h00, regRdata});
	endtask
	// request held until an executing boundary takes it
	task automatic go(input ifs_pkg::ifs_ctl_e k, input logic [12:0] t, input logic [2:0] b);
		@(posedge ref_clk);
		ctlReq <= {k, t};
		bankReq <= b;
		do
			@(negedge ref_clk);
		while (!(cycleEnd && execValid));
		@(posedge ref_clk);
		ctlReq <= '0;
		bankReq <= '0;
		@(negedge ref_clk);
	endtask
	// main sequence
	initial begin
		repeat (12) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(negedge ref_clk);
		ck("romAddr", 16'h0000, romAddr);
		nxt();
		ck("ptr", 16'h0001, 16'(instrPointer));
		ck("word", 16'hA5A5, execWord);
		rd(8'h06, 8'h01);
		rd(8'h05, 8'h00);
		go(ifs_pkg::CTL_JUMP, 13'h1F0E, 3'h0);
		ck("ptr", 16'h1F0E, 16'(instrPointer));
		ck("valid", 16'h0000, 16'(execValid));
		nxt();
		ck("word", 16'hBAAB, execWord);
		wr(8'h06, 8'h33);
		nxt();
		ck("ptr", 16'h1F33, 16'(instrPointer));
		nxt();
		go(ifs_pkg::CTL_NONE, 13'h0000, 3'h7);
		ck("bank", 16'h0000, 16'(romBankSelect));
		nxt();
		ck("bank", 16'h0003, 16'(romBankSelect));
		ck("romAddr", 16'h7F36, romAddr);
		go(ifs_pkg::CTL_TMR0, 13'h0000, 3'h0);
		ck("ptr", 16'h0008, 16'(instrPointer));
		nxt();
		go(ifs_pkg::CTL_SKIP, 13'h0000, 3'h0);
		ck("ptr", 16'h000A, 16'(instrPointer));
		nxt();
		ck("word", 16'hC5AF, execWord);
		go(ifs_pkg::CTL_TMR1, 13'h0000, 3'h0);
		ck("ptr", 16'h000C, 16'(instrPointer));
		go(ifs_pkg::CTL_RET, 13'h0123, 3'h0);
		ck("ptr", 16'h0123, 16'(instrPointer));
		@(posedge ref_clk);
		waveReq <= 1'b1;
		waveStart <= 11'h7FF;
		do
			@(negedge ref_clk);
		while (!waveDone);
		ck("wave", 16'h5A45, waveData);
		results();
	end
	// watchdog
	initial begin
		repeat (2000) @(posedge ref_clk);
		fails++;
		results();
	end
endmodule
